// ==== pls_power_limit_status.v ====
`timescale 1ns/1ps
`include "pls_map.vh"
module pls_power_limit_status (
  clk, // 25 MHz clock
  reset, // sync reset, active high
  nvm_limit, // stored threshold code
  cmd_code, // command code
  wr_strobe, // write byte pulse
  wr_data, // write byte data
  rd_strobe, // read byte pulse
  rd_data, // read byte data, registered
  rd_valid, // read data valid pulse
  send_byte, // command-only pulse
  pin_telemetry, // input power, watts
  pin_sample, // new telemetry sample pulse
  ov_fixed_fault, // fixed overvoltage fault pin
  ov_track_fault, // tracking overvoltage fault pin
  ov_track_warn, // tracking overvoltage warning pin
  uv_track_warn, // tracking undervoltage warning pin
  uv_track_fault, // tracking undervoltage fault pin
  valley_oc, // valley overcurrent limit pin
  pin_max_threshold, // maximum input power threshold
  input_power_warning_flag // latched warning
);
  input wire clk; // 25 MHz clock
  input wire reset; // sync reset, active high
  input wire [2:0] nvm_limit; // stored threshold code
  input wire [7:0] cmd_code; // command code
  input wire wr_strobe; // write byte pulse
  input wire [7:0] wr_data; // write byte data
  input wire rd_strobe; // read byte pulse
  output wire [7:0] rd_data; // read byte data, registered
  output wire rd_valid; // read data valid pulse
  input wire send_byte; // command-only pulse
  input wire [`PLS_PWR_W-1:0] pin_telemetry; // input power, watts
  input wire pin_sample; // new telemetry sample pulse
  input wire ov_fixed_fault; // fixed overvoltage fault pin
  input wire ov_track_fault; // tracking overvoltage fault pin
  input wire ov_track_warn; // tracking overvoltage warning pin
  input wire uv_track_warn; // tracking undervoltage warning pin
  input wire uv_track_fault; // tracking undervoltage fault pin
  input wire valley_oc; // valley overcurrent limit pin
  output wire [`PLS_PWR_W-1:0] pin_max_threshold; // maximum input power threshold
  output wire input_power_warning_flag; // latched warning

  reg [2:0] limit_reg;
  reg [2:0] limit_next;
  reg nvm_load_reg;
  reg [`PLS_PWR_W-1:0] threshold;
  reg [`PLS_PWR_W-1:0] max_threshold_reg;
  reg over_reg;
  reg over_next;
  reg [4:0] s1_reg;
  reg [4:0] s2_reg;
  reg [4:0] s3_reg;
  reg [4:0] filt_reg;
  reg [7:0] rd_data_reg;
  reg [7:0] rd_data_next;
  reg rd_valid_reg;
  wire [4:0] filt_next;
  wire [4:0] pins_raw;
  wire ov_any;
  wire ov_fault_cond;
  wire ov_warn_cond;
  wire uv_warn_cond;
  wire uv_fault_cond;
  wire oc_cond;
  wire ocuv_cond;
  wire clear_all_faults_command;
  wire wr_limit;
  wire wr_vout;
  wire wr_iout;
  wire wr_input;
  wire clr_ov_fault;
  wire clr_ov_warn;
  wire clr_uv_warn;
  wire clr_uv_fault;
  wire clr_oc;
  wire clr_ocuv;
  wire clr_power_warn;
  wire [7:0] vout_status;
  wire [7:0] iout_status;
  wire [7:0] input_status;
  wire output_overvoltage_fault_flag;
  wire output_overvoltage_warning_flag;
  wire output_undervoltage_warning_flag;
  wire output_undervoltage_fault_flag;
  wire valley_overcurrent_flag;
  wire overcurrent_with_undervoltage_flag;

  // threshold decode
  always @*
  begin
    case (limit_reg)
      3'h0: threshold = `PLS_TH_0;
      3'h1: threshold = `PLS_TH_1;
      3'h2: threshold = `PLS_TH_2;
      3'h3: threshold = `PLS_TH_3;
      3'h4: threshold = `PLS_TH_4;
      3'h5: threshold = `PLS_TH_5;
      3'h6: threshold = `PLS_TH_6;
      default: threshold = `PLS_TH_7;
    endcase
  end

  // limit register, nvm load right after reset release
  assign wr_limit = wr_strobe && (cmd_code == `PLS_CMD_PIN_LIMIT);
  always @*
  begin
    limit_next = limit_reg;
    if (nvm_load_reg)
      limit_next = nvm_limit;
    else if (wr_limit)
      limit_next = wr_data[`PLS_LIMIT_MSB:`PLS_LIMIT_LSB];
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      limit_reg <= `PLS_LIMIT_RESET;
      nvm_load_reg <= 1'h1;
    end
    else
    begin
      limit_reg <= limit_next;
      nvm_load_reg <= 1'h0;
    end
  end

  // comparator result held between samples
  always @*
  begin
    over_next = over_reg;
    if (pin_sample)
      over_next = (pin_telemetry > threshold);
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      over_reg <= 1'h0;
      max_threshold_reg <= `PLS_TH_0;
    end
    else
    begin
      over_reg <= over_next;
      max_threshold_reg <= threshold;
    end
  end
  assign pin_max_threshold = max_threshold_reg;

  // fault pins: three stage sync, a change counts once stages 2 and 3 agree
  assign ov_any = ov_fixed_fault | ov_track_fault;
  assign pins_raw = {valley_oc, uv_track_fault, uv_track_warn, ov_track_warn, ov_any};
  assign filt_next = (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
  always @(posedge clk)
  begin
    if (reset)
    begin
      s1_reg <= 5'h00;
      s2_reg <= 5'h00;
      s3_reg <= 5'h00;
      filt_reg <= 5'h00;
    end
    else
    begin
      s1_reg <= pins_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  assign ov_fault_cond = filt_reg[0];
  assign ov_warn_cond = filt_reg[1];
  assign uv_warn_cond = filt_reg[2];
  assign uv_fault_cond = filt_reg[3];
  assign oc_cond = filt_reg[4];
  assign ocuv_cond = filt_reg[4] & filt_reg[3];

  // clear decode: clear-all command or write one to the bit
  assign clear_all_faults_command = send_byte && (cmd_code == `PLS_CMD_CLEAR_ALL);
  assign wr_vout = wr_strobe && (cmd_code == `PLS_CMD_VOUT_STATUS);
  assign wr_iout = wr_strobe && (cmd_code == `PLS_CMD_IOUT_STATUS);
  assign wr_input = wr_strobe && (cmd_code == `PLS_CMD_INPUT_STATUS);
  assign clr_ov_fault = clear_all_faults_command | (wr_vout & wr_data[`PLS_OV_FAULT_BIT]);
  assign clr_ov_warn = clear_all_faults_command | (wr_vout & wr_data[`PLS_OV_WARN_BIT]);
  assign clr_uv_warn = clear_all_faults_command | (wr_vout & wr_data[`PLS_UV_WARN_BIT]);
  assign clr_uv_fault = clear_all_faults_command | (wr_vout & wr_data[`PLS_UV_FAULT_BIT]);
  // read-only bit: only clear-all clears it
  assign clr_oc = clear_all_faults_command;
  assign clr_ocuv = clear_all_faults_command | (wr_iout & wr_data[`PLS_OCUV_BIT]);
  assign clr_power_warn = clear_all_faults_command | (wr_input & wr_data[`PLS_INPUT_OPW_BIT]);

  pls_sticky_flag u_ov_fault (
    .clk(clk),
    .reset(reset),
    .event_level(ov_fault_cond),
    .clear(clr_ov_fault),
    .flag(output_overvoltage_fault_flag)
  );

  pls_sticky_flag u_ov_warn (
    .clk(clk),
    .reset(reset),
    .event_level(ov_warn_cond),
    .clear(clr_ov_warn),
    .flag(output_overvoltage_warning_flag)
  );

  pls_sticky_flag u_uv_warn (
    .clk(clk),
    .reset(reset),
    .event_level(uv_warn_cond),
    .clear(clr_uv_warn),
    .flag(output_undervoltage_warning_flag)
  );

  pls_sticky_flag u_uv_fault (
    .clk(clk),
    .reset(reset),
    .event_level(uv_fault_cond),
    .clear(clr_uv_fault),
    .flag(output_undervoltage_fault_flag)
  );

  pls_sticky_flag u_valley_oc (
    .clk(clk),
    .reset(reset),
    .event_level(oc_cond),
    .clear(clr_oc),
    .flag(valley_overcurrent_flag)
  );

  pls_sticky_flag u_oc_uv (
    .clk(clk),
    .reset(reset),
    .event_level(ocuv_cond),
    .clear(clr_ocuv),
    .flag(overcurrent_with_undervoltage_flag)
  );

  pls_sticky_flag u_power_warn (
    .clk(clk),
    .reset(reset),
    .event_level(over_reg),
    .clear(clr_power_warn),
    .flag(input_power_warning_flag)
  );

  assign vout_status = {output_overvoltage_fault_flag, output_overvoltage_warning_flag,
                        output_undervoltage_warning_flag, output_undervoltage_fault_flag, 4'h0};
  assign iout_status = {valley_overcurrent_flag, overcurrent_with_undervoltage_flag, 6'h00};
  assign input_status = {7'h00, input_power_warning_flag};

  // read byte mux, registered one cycle after strobe
  always @*
  begin
    rd_data_next = rd_data_reg;
    if (rd_strobe)
    begin
      case (cmd_code)
        `PLS_CMD_PIN_LIMIT: rd_data_next = {5'h00, limit_reg};
        `PLS_CMD_VOUT_STATUS: rd_data_next = vout_status;
        `PLS_CMD_IOUT_STATUS: rd_data_next = iout_status;
        `PLS_CMD_INPUT_STATUS: rd_data_next = input_status;
        default: rd_data_next = 8'h00;
      endcase
    end
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      rd_data_reg <= `PLS_STATUS_RESET;
      rd_valid_reg <= 1'h0;
    end
    else
    begin
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_strobe;
    end
  end
  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;
endmodule // pls_power_limit_status

// ==== pls_map.vh ====
`ifndef PLS_MAP_VH
`define PLS_MAP_VH
// command codes
`define PLS_CMD_PIN_LIMIT 8'h6B
`define PLS_CMD_VOUT_STATUS 8'h7A
`define PLS_CMD_IOUT_STATUS 8'h7B
`define PLS_CMD_INPUT_STATUS 8'h7C
`define PLS_CMD_CLEAR_ALL 8'h03
// field positions
`define PLS_LIMIT_MSB 2
`define PLS_LIMIT_LSB 0
`define PLS_OV_FAULT_BIT 7
`define PLS_OV_WARN_BIT 6
`define PLS_UV_WARN_BIT 5
`define PLS_UV_FAULT_BIT 4
`define PLS_OC_BIT 7
`define PLS_OCUV_BIT 6
`define PLS_INPUT_OPW_BIT 0
// reset values
`define PLS_STATUS_RESET 8'h00
`define PLS_LIMIT_RESET 3'h0
// thresholds in watts
`define PLS_TH_0 10'h1FE
`define PLS_TH_1 10'h1E0
`define PLS_TH_2 10'h1A4
`define PLS_TH_3 10'h168
`define PLS_TH_4 10'h12C
`define PLS_TH_5 10'h0F0
`define PLS_TH_6 10'h0B4
`define PLS_TH_7 10'h078
`define PLS_PWR_W 10
`endif

// ==== pls_sticky_flag.v ====
`timescale 1ns/1ps
module pls_sticky_flag (
  clk, // clock
  reset, // sync reset
  event_level, // condition present
  clear, // clear request
  flag // latched flag
);
  input wire clk; // clock
  input wire reset; // sync reset
  input wire event_level; // condition present
  input wire clear; // clear request
  output reg flag; // latched flag

  // set wins over clear, so a persisting condition re-sets at once
  always @(posedge clk)
  begin
    if (reset)
      flag <= 1'h0;
    else if (event_level)
      flag <= 1'h1;
    else if (clear)
      flag <= 1'h0;
  end
endmodule // pls_sticky_flag

// ==== pls_power_limit_status_props.sv ====
`timescale 1ns/1ps
module pls_power_limit_status_props (
  input wire clk, // clock
  input wire reset, // sync reset
  input wire [7:0] cmd_code, // command
  input wire rd_strobe, // read pulse
  input wire [7:0] rd_data, // read byte
  input wire rd_valid, // read valid
  input wire pin_sample, // sample pulse
  input wire [9:0] pin_telemetry, // power
  input wire [9:0] pin_max_threshold, // threshold
  input wire input_power_warning_flag, // warning
  input wire ov_fixed_fault, // ov fault
  input wire valley_oc // oc limit
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_ovf_held; ov_fixed_fault [*6]; endsequence
  sequence s_ocl_held; valley_oc [*6]; endsequence
  AST_RD_ANSWER: assert property (rd_strobe |=> rd_valid) else $error("no read answer");
  AST_RD_SINGLE: assert property (!rd_strobe |=> !rd_valid) else $error("stray read valid");
  AST_LIMIT_TOP: assert property (rd_strobe && cmd_code == 8'h6B |=> rd_data[7:3] == 5'h00)
    else $error("limit top bits set");
  AST_VOUT_LOW: assert property (rd_strobe && cmd_code == 8'h7A |=> rd_data[3:0] == 4'h0)
    else $error("voltage status low bits set");
  AST_IOUT_LOW: assert property (rd_strobe && cmd_code == 8'h7B |=> rd_data[5:0] == 6'h00)
    else $error("current status low bits set");
  AST_PWR_WARN: assert property (pin_sample && pin_telemetry > pin_max_threshold |=> ##1 input_power_warning_flag)
    else $error("power warning not set");
  AST_MAX_SET: assert property (pin_max_threshold inside {10'h1FE, 10'h1E0, 10'h1A4, 10'h168,
    10'h12C, 10'h0F0, 10'h0B4, 10'h078}) else $error("threshold not in table");
  AST_OVF_SEEN: assert property (s_ovf_held ##0 (rd_strobe && cmd_code == 8'h7A) |=> rd_data[7])
    else $error("overvoltage flag missing");
  AST_OCL_SEEN: assert property (s_ocl_held ##0 (rd_strobe && cmd_code == 8'h7B) |=> rd_data[7])
    else $error("overcurrent flag missing");
endmodule // pls_power_limit_status_props
bind pls_power_limit_status pls_power_limit_status_props i_pls_power_limit_status_props (.clk, .reset,
  .cmd_code, .rd_strobe, .rd_data, .rd_valid, .pin_sample, .pin_telemetry, .pin_max_threshold,
  .input_power_warning_flag, .ov_fixed_fault, .valley_oc);

// ==== pls_host_model.sv ====
`timescale 1ns/1ps
module pls_host_model (
  input wire clk, // clock
  output logic [7:0] cmd_code, // command
  output logic wr_strobe, // write pulse
  output logic [7:0] wr_data, // write byte
  output logic rd_strobe, // read pulse
  output logic send_byte, // command only
  input wire [7:0] rd_data, // read byte
  input wire rd_valid // read valid
);
  initial
  begin
    cmd_code = 8'h00;
    wr_strobe = 1'h0;
    wr_data = 8'h00;
    rd_strobe = 1'h0;
    send_byte = 1'h0;
  end
  task wr(input logic [7:0] c, input logic [7:0] d);
    begin
      @(posedge clk);
      cmd_code <= c;
      wr_data <= d;
      wr_strobe <= 1'h1;
      @(posedge clk);
      wr_strobe <= 1'h0;
      wr_data <= ~d;
    end
  endtask
  // strobe taken at one edge, answer taken at the edge where rd_valid stands
  task rd(input logic [7:0] c, output logic [7:0] d, output logic v);
    begin
      @(posedge clk);
      cmd_code <= c;
      rd_strobe <= 1'h1;
      @(posedge clk);
      rd_strobe <= 1'h0;
      @(posedge clk);
      d = rd_data;
      v = rd_valid;
    end
  endtask
  task clr;
    begin
      @(posedge clk);
      cmd_code <= 8'h03;
      send_byte <= 1'h1;
      @(posedge clk);
      send_byte <= 1'h0;
    end
  endtask
endmodule // pls_host_model

// ==== pls_power_limit_status_tb.sv ====
`timescale 1ns/1ps
module pls_power_limit_status_tb;
  localparam logic [79:0] TH = {10'h078, 10'h0B4, 10'h0F0, 10'h12C, 10'h168, 10'h1A4, 10'h1E0, 10'h1FE};
  localparam logic [41:0] FV = {6'h30, 6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01};
  localparam logic [55:0] EA = {8'h10, 8'h00, 8'h10, 8'h20, 8'h40, 8'h80, 8'h80};
  localparam logic [55:0] EB = {8'hC0, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic clk, reset, pin_sample, rd_strobe, wr_strobe, send_byte, rd_valid, input_power_warning_flag, v;
  logic [2:0] nvm_limit;
  logic [5:0] flt;
  logic [7:0] cmd_code, wr_data, rd_data, d;
  logic [9:0] pin_telemetry, pin_max_threshold;
  integer failures, num_checks, i;
  pls_power_limit_status i_pls_power_limit_status (.clk(clk), .reset(reset), .nvm_limit(nvm_limit),
    .cmd_code(cmd_code), .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_strobe(rd_strobe), .rd_data(rd_data),
    .rd_valid(rd_valid), .send_byte(send_byte), .pin_telemetry(pin_telemetry), .pin_sample(pin_sample),
    .ov_fixed_fault(flt[0]), .ov_track_fault(flt[1]), .ov_track_warn(flt[2]), .uv_track_warn(flt[3]),
    .uv_track_fault(flt[4]), .valley_oc(flt[5]), .pin_max_threshold(pin_max_threshold),
    .input_power_warning_flag(input_power_warning_flag));
  pls_host_model i_pls_host_model (.clk(clk), .cmd_code(cmd_code), .wr_strobe(wr_strobe), .wr_data(wr_data),
    .rd_strobe(rd_strobe), .send_byte(send_byte), .rd_data(rd_data), .rd_valid(rd_valid));
  always #20 clk = ~clk;
  task chk(input logic [9:0] g, input logic [9:0] e);
    begin
      num_checks = num_checks + 1;
      if (g !== e)
      begin
        failures = failures + 1;
        $display("Error %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  task rc(input logic [7:0] c, input logic [7:0] e);
    begin
      i_pls_host_model.rd(c, d, v);
      chk({9'h000, v}, 10'h001);
      chk({2'h0, d}, {2'h0, e});
    end
  endtask
  task smp(input logic [9:0] t);
    begin
      @(posedge clk);
      pin_telemetry <= t;
      pin_sample <= 1'h1;
      @(posedge clk);
      pin_sample <= 1'h0;
      repeat (2) @(posedge clk);
    end
  endtask
  task give_verdict;
    begin
      if (failures == 0 && num_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial
  begin
    repeat (6000) @(posedge clk);
    failures = failures + 1;
    give_verdict;
  end
  initial
  begin
    clk = 1'h0;
    reset = 1'h1;
    nvm_limit = 3'h2;
    pin_telemetry = 10'h000;
    pin_sample = 1'h0;
    flt = 6'h00;
    failures = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    reset <= 1'h0;
    rc(8'h6B, 8'h02);
    chk(pin_max_threshold, 10'h1A4);
    rc(8'h55, 8'h00);
    for (i = 0; i < 8; i = i + 1)
    begin
      i_pls_host_model.wr(8'h6B, 8'hF8 | i[7:0]);
      rc(8'h6B, i[7:0]);
      chk(pin_max_threshold, TH[i*10+:10]);
    end
    smp(10'h078);
    rc(8'h7C, 8'h00);
    smp(10'h079);
    rc(8'h7C, 8'h01);
    chk({9'h000, input_power_warning_flag}, 10'h001);
    i_pls_host_model.wr(8'h7C, 8'h01);
    rc(8'h7C, 8'h01);
    smp(10'h000);
    i_pls_host_model.wr(8'h7C, 8'h01);
    rc(8'h7C, 8'h00);
    chk({9'h000, input_power_warning_flag}, 10'h000);
    i_pls_host_model.wr(8'h6B, 8'h06);
    smp(10'h0B5);
    rc(8'h7C, 8'h01);
    smp(10'h000);
    i_pls_host_model.clr;
    rc(8'h7C, 8'h00);
    for (i = 0; i < 7; i = i + 1)
    begin
      @(posedge clk) flt <= FV[i*6+:6];
      repeat (6) @(posedge clk);
      rc(8'h7A, EA[i*8+:8]);
      rc(8'h7B, EB[i*8+:8]);
      i_pls_host_model.wr(8'h7A, 8'hFF);
      rc(8'h7A, EA[i*8+:8]);
      i_pls_host_model.wr(8'h7B, 8'hFF);
      rc(8'h7B, EB[i*8+:8]);
      @(posedge clk) flt <= 6'h00;
      repeat (6) @(posedge clk);
      i_pls_host_model.wr(8'h7A, 8'hFF);
      rc(8'h7A, 8'h00);
      i_pls_host_model.wr(8'h7B, 8'hFF);
      rc(8'h7B, EB[i*8+:8] & 8'h80);
      i_pls_host_model.clr;
      rc(8'h7B, 8'h00);
    end
    give_verdict;
  end
endmodule // pls_power_limit_status_tb
